//--- logic/iqc_consts.vh
// Constants for the I/Q quadrature correction block: offsets, fields, resets, loop figures
`ifndef IQC_CONSTS_VH
`define IQC_CONSTS_VH

// Register byte offsets
`define IQC_OFS_CTRL_AB      8'h00
`define IQC_OFS_CTRL_CD      8'h04
`define IQC_OFS_DCI_AB       8'h08
`define IQC_OFS_DCQ_AB       8'h0c
`define IQC_OFS_DCI_CD       8'h10
`define IQC_OFS_DCQ_CD       8'h14
`define IQC_OFS_PHASE_AB     8'h18
`define IQC_OFS_AMP_AB       8'h1c
`define IQC_OFS_PHASE_CD     8'h20
`define IQC_OFS_AMP_CD       8'h24
`define IQC_OFS_INCTRL       8'h28
`define IQC_LAST_INDEX       4'ha
`define IQC_NO_INDEX         4'hf

// Correction control fields
`define IQC_GAIN_SEL_MSB     15
`define IQC_GAIN_SEL_LSB     12
`define IQC_SKEW_SEL_MSB     11
`define IQC_SKEW_SEL_LSB     8
`define IQC_OFFS_SEL_MSB     7
`define IQC_OFFS_SEL_LSB     4
`define IQC_AMP_EN_BIT       2
`define IQC_PHASE_EN_BIT     1
`define IQC_DC_EN_BIT        0

// Input control fields
`define IQC_CPLX_AB_BIT      24
`define IQC_CPLX_CD_BIT      25
`define IQC_LVDS_BIT         0

// Reset values
`define IQC_RST_CTRL         16'h0000
`define IQC_RST_VALUE        16'h0000

// Loop figures: decimation is 2^(base + sel), sel clamped at max
`define IQC_DECIM_BASE       5'd12
`define IQC_DECIM_MAX_SEL    4'd11
`define IQC_COEF_FRAC        13

`endif

//--- logic/iqc_sat16.v
// Saturation of a signed 18-bit intermediate to a signed 16-bit sample
`timescale 1ns/100ps
module iqc_sat16 (
    // Wide signed value
    input  wire [17:0] din,
    // Clamped sample
    output reg  [15:0] dout
);

    // Top three bits must agree, otherwise clamp toward the sign
    always @* begin
        if (din[17:15] == 3'b000 || din[17:15] == 3'b111) begin
            dout = din[15:0];
        end else if (din[17]) begin
            dout = 16'h8000;
        end else begin
            dout = 16'h7fff;
        end
    end

endmodule

//--- logic/iqc_rate_tick.v
// Decimation strobe: one pulse every 2^(12+sel) input samples
`timescale 1ns/100ps
`include "iqc_consts.vh"
module iqc_rate_tick (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Sample strobe and rate select
    input  wire       sampleEn,
    input  wire [3:0] rateSel,
    // Decimated strobe
    output reg        tick
);

    reg  [23:0] cntQ;
    wire [3:0]  selClamp;
    wire [4:0]  shiftAmt;
    wire [23:0] mask;

    // Values above the top code behave as the top code
    assign selClamp = (rateSel > `IQC_DECIM_MAX_SEL) ? `IQC_DECIM_MAX_SEL : rateSel;
    assign shiftAmt = `IQC_DECIM_BASE + {1'b0, selClamp};
    assign mask     = ~(24'hffffff << shiftAmt);

    // Free counter; masking lets the select change without a restart
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cntQ <= 24'h000000;
            tick <= 1'b0;
        end else begin
            tick <= sampleEn && ((cntQ & mask) == mask);
            if (sampleEn) begin
                cntQ <= cntQ + 24'h000001;
            end
        end
    end

endmodule

//--- logic/iqc_correction.v
// I/Q quadrature correction for the AB and CD input pairs, with Avalon-MM registers
`timescale 1ns/100ps
`include "iqc_consts.vh"
module iqc_correction (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Avalon-MM slave
    input  wire [7:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output wire [31:0] readdata,
    output wire        waitrequest,
    // Input samples from the ADC ports
    input  wire        adcValid,
    input  wire [15:0] adcA,
    input  wire [15:0] adcB,
    input  wire [15:0] adcC,
    input  wire [15:0] adcD,
    // Corrected samples toward the crossbar
    output wire        corrValid,
    output wire [15:0] corrA,
    output wire [15:0] corrB,
    output wire [15:0] corrC,
    output wire [15:0] corrD
);

    // Register index from a byte address; unmapped gives the empty index
    function [3:0] regIndex;
        input [7:0] addr;
        begin
            if (addr[7:6] == 2'b00 && addr[5:2] <= `IQC_LAST_INDEX) begin
                regIndex = addr[5:2];
            end else begin
                regIndex = `IQC_NO_INDEX;
            end
        end
    endfunction

    // Byte-lane merge of the low half word
    function [15:0] mergeLow;
        input [15:0] oldVal;
        input [15:0] newVal;
        input [1:0]  be;
        begin
            mergeLow = {be[1] ? newVal[15:8] : oldVal[15:8], be[0] ? newVal[7:0] : oldVal[7:0]};
        end
    endfunction

    // Magnitude of a signed sample, one bit wider so full scale survives
    function [16:0] magOf;
        input [15:0] s;
        begin
            magOf = s[15] ? (17'h00000 - {s[15], s}) : {1'b0, s};
        end
    endfunction

    // Bus handshake: one wait state, then the answer
    reg         ackQ;
    reg  [31:0] readdataQ;
    reg  [31:0] rdMux;
    wire        busReq;
    wire [3:0]  busIdx;
    wire        wrStrobe;

    assign busReq      = read | write;
    assign busIdx      = regIndex(address);
    assign waitrequest = busReq & ~ackQ;
    assign wrStrobe    = write & ackQ;
    assign readdata    = readdataQ;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ackQ      <= 1'b0;
            readdataQ <= 32'h00000000;
        end else begin
            ackQ <= busReq & ~ackQ;
            if (read & ~ackQ) begin
                readdataQ <= rdMux;
            end
        end
    end

    // Input control: complex pair bits and the input standard
    reg cplxAbQ;
    reg cplxCdQ;
    reg lvdsQ;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cplxAbQ <= 1'b0;
            cplxCdQ <= 1'b0;
            lvdsQ   <= 1'b0;
        end else if (wrStrobe && busIdx == `IQC_OFS_INCTRL >> 2) begin
            if (byteenable[3]) begin
                cplxAbQ <= writedata[`IQC_CPLX_AB_BIT];
                cplxCdQ <= writedata[`IQC_CPLX_CD_BIT];
            end
            if (byteenable[0]) begin
                lvdsQ <= writedata[`IQC_LVDS_BIT];
            end
        end
    end

    // Sample pipeline strobes
    reg v1Q;
    reg v2Q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            v1Q <= 1'b0;
            v2Q <= 1'b0;
        end else begin
            v1Q <= adcValid;
            v2Q <= v1Q;
        end
    end

    assign corrValid = v2Q;

    // One correction lane per pair: p = 0 is A/B, p = 1 is C/D
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : pairGen
            localparam [3:0] IDX_CTRL  = p;
            localparam [3:0] IDX_DCI   = 2 + 2 * p;
            localparam [3:0] IDX_DCQ   = 3 + 2 * p;
            localparam [3:0] IDX_PHASE = 6 + 2 * p;
            localparam [3:0] IDX_AMP   = 7 + 2 * p;

            reg [15:0] ctrlQ;
            reg [15:0] dcIQ;
            reg [15:0] dcQQ;
            reg [15:0] phaseQ;
            reg [15:0] ampQ;

            // Software-written values; bit 3 is stored but steers nothing
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    ctrlQ  <= `IQC_RST_CTRL;
                    dcIQ   <= `IQC_RST_VALUE;
                    dcQQ   <= `IQC_RST_VALUE;
                    phaseQ <= `IQC_RST_VALUE;
                    ampQ   <= `IQC_RST_VALUE;
                end else if (wrStrobe) begin
                    if (busIdx == IDX_CTRL) begin
                        ctrlQ <= mergeLow(ctrlQ, writedata[15:0], byteenable[1:0]);
                    end
                    if (busIdx == IDX_DCI) begin
                        dcIQ <= mergeLow(dcIQ, writedata[15:0], byteenable[1:0]);
                    end
                    if (busIdx == IDX_DCQ) begin
                        dcQQ <= mergeLow(dcQQ, writedata[15:0], byteenable[1:0]);
                    end
                    if (busIdx == IDX_PHASE) begin
                        phaseQ <= mergeLow(phaseQ, writedata[15:0], byteenable[1:0]);
                    end
                    if (busIdx == IDX_AMP) begin
                        ampQ <= mergeLow(ampQ, writedata[15:0], byteenable[1:0]);
                    end
                end
            end

            // Mode: real pairs and differential inputs bypass everything
            wire cplx   = ((p == 0) ? cplxAbQ : cplxCdQ) & ~lvdsQ;
            wire dcAuto = ctrlQ[`IQC_DC_EN_BIT];
            wire phAuto = ctrlQ[`IQC_PHASE_EN_BIT];
            wire amAuto = ctrlQ[`IQC_AMP_EN_BIT];

            wire [15:0] iIn = (p == 0) ? adcA : adcC;
            wire [15:0] qIn = (p == 0) ? adcB : adcD;

            // Estimates of the automatic loops
            reg  [15:0] dcEstIQ;
            reg  [15:0] dcEstQQ;
            reg  [13:0] phEstQ;
            reg  [13:0] amEstQ;

            // Values in force: estimate when automatic, else the written one
            wire [15:0] dcIUse = dcAuto ? dcEstIQ : dcIQ;
            wire [15:0] dcQUse = dcAuto ? dcEstQQ : dcQQ;
            wire [13:0] phUse  = phAuto ? phEstQ : phaseQ[13:0];
            wire [13:0] amUse  = amAuto ? amEstQ : ampQ[13:0];

            // Stage 1: dc removal with saturation
            wire [15:0] iDcSat;
            wire [15:0] qDcSat;
            iqc_sat16 u_satIDc (
                .din  ({{2{iIn[15]}}, iIn} - {{2{dcIUse[15]}}, dcIUse}),
                .dout (iDcSat)
            );
            iqc_sat16 u_satQDc (
                .din  ({{2{qIn[15]}}, qIn} - {{2{dcQUse[15]}}, dcQUse}),
                .dout (qDcSat)
            );

            reg [15:0] iDcQ;
            reg [15:0] qDcQ;
            reg [15:0] iRawQ;
            reg [15:0] qRawQ;

            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    iDcQ  <= 16'h0000;
                    qDcQ  <= 16'h0000;
                    iRawQ <= 16'h0000;
                    qRawQ <= 16'h0000;
                end else if (adcValid) begin
                    iDcQ  <= iDcSat;
                    qDcQ  <= qDcSat;
                    iRawQ <= iIn;
                    qRawQ <= qIn;
                end
            end

            // Stage 2: coefficient times Q, scaled as a signed 1.13 fraction
            wire signed [29:0] phProd = $signed(phUse) * $signed(qDcQ);
            wire signed [29:0] amProd = $signed(amUse) * $signed(qDcQ);
            wire [15:0] iCorSat;
            wire [15:0] qCorSat;
            iqc_sat16 u_satICor (
                .din  ({{2{iDcQ[15]}}, iDcQ} + {phProd[29], phProd[29:`IQC_COEF_FRAC]}),
                .dout (iCorSat)
            );
            iqc_sat16 u_satQCor (
                .din  ({{2{qDcQ[15]}}, qDcQ} + {amProd[29], amProd[29:`IQC_COEF_FRAC]}),
                .dout (qCorSat)
            );

            reg [15:0] iOutQ;
            reg [15:0] qOutQ;

            // Real mode hands the raw samples on untouched
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    iOutQ <= 16'h0000;
                    qOutQ <= 16'h0000;
                end else if (v1Q) begin
                    iOutQ <= cplx ? iCorSat : iRawQ;
                    qOutQ <= cplx ? qCorSat : qRawQ;
                end
            end

            // Decimation strobes, one per loop
            wire dcTick;
            wire phTick;
            wire amTick;
            iqc_rate_tick u_dcRate (
                .clk      (clk),
                .rstn     (rstn),
                .sampleEn (adcValid),
                .rateSel  (ctrlQ[`IQC_OFFS_SEL_MSB:`IQC_OFFS_SEL_LSB]),
                .tick     (dcTick)
            );
            iqc_rate_tick u_phRate (
                .clk      (clk),
                .rstn     (rstn),
                .sampleEn (adcValid),
                .rateSel  (ctrlQ[`IQC_SKEW_SEL_MSB:`IQC_SKEW_SEL_LSB]),
                .tick     (phTick)
            );
            iqc_rate_tick u_amRate (
                .clk      (clk),
                .rstn     (rstn),
                .sampleEn (adcValid),
                .rateSel  (ctrlQ[`IQC_GAIN_SEL_MSB:`IQC_GAIN_SEL_LSB]),
                .tick     (amTick)
            );

            // Dc loop: block mean of the raw input, held between strobes
            reg  signed [39:0] dcAccIQ;
            reg  signed [39:0] dcAccQQ;
            wire [3:0]  dcSel   = ctrlQ[`IQC_OFFS_SEL_MSB:`IQC_OFFS_SEL_LSB];
            wire [4:0]  dcShift = `IQC_DECIM_BASE + ((dcSel > `IQC_DECIM_MAX_SEL) ? `IQC_DECIM_MAX_SEL : dcSel);
            wire signed [39:0] dcMeanI = dcAccIQ >>> dcShift;
            wire signed [39:0] dcMeanQ = dcAccQQ >>> dcShift;
            wire dcRun = dcAuto & cplx;

            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    dcAccIQ <= 40'sh0000000000;
                    dcAccQQ <= 40'sh0000000000;
                    dcEstIQ <= 16'h0000;
                    dcEstQQ <= 16'h0000;
                end else if (!dcRun) begin
                    dcAccIQ <= 40'sh0000000000;
                    dcAccQQ <= 40'sh0000000000;
                end else if (dcTick) begin
                    dcEstIQ <= dcMeanI[15:0];
                    dcEstQQ <= dcMeanQ[15:0];
                    dcAccIQ <= 40'sh0000000000;
                    dcAccQQ <= 40'sh0000000000;
                end else if (adcValid) begin
                    dcAccIQ <= dcAccIQ + {{24{iIn[15]}}, iIn};
                    dcAccQQ <= dcAccQQ + {{24{qIn[15]}}, qIn};
                end
            end

            // Phase loop: sign correlation of corrected I and Q, one LSB step per strobe
            reg signed [25:0] phAccQ;
            wire phRun = phAuto & cplx;

            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    phAccQ <= 26'sh0000000;
                    phEstQ <= 14'h0000;
                end else if (!phRun) begin
                    phAccQ <= 26'sh0000000;
                end else if (phTick) begin
                    // Positive correlation means too much Q leaks into I
                    if (phAccQ > 0 && phEstQ != 14'h2000) begin
                        phEstQ <= phEstQ - 14'h0001;
                    end else if (phAccQ < 0 && phEstQ != 14'h1fff) begin
                        phEstQ <= phEstQ + 14'h0001;
                    end
                    phAccQ <= 26'sh0000000;
                end else if (v2Q) begin
                    phAccQ <= (iOutQ[15] ^ qOutQ[15]) ? phAccQ - 26'sh0000001 : phAccQ + 26'sh0000001;
                end
            end

            // Amplitude loop: integrate |I| - |Q|, raise the gain while Q is smaller
            reg  signed [41:0] amAccQ;
            wire signed [17:0] magDiff = $signed({1'b0, magOf(iOutQ)}) - $signed({1'b0, magOf(qOutQ)});
            wire amRun = amAuto & cplx;

            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    amAccQ <= 42'sh00000000000;
                    amEstQ <= 14'h0000;
                end else if (!amRun) begin
                    amAccQ <= 42'sh00000000000;
                end else if (amTick) begin
                    if (amAccQ > 0 && amEstQ != 14'h1fff) begin
                        amEstQ <= amEstQ + 14'h0001;
                    end else if (amAccQ < 0 && amEstQ != 14'h2000) begin
                        amEstQ <= amEstQ - 14'h0001;
                    end
                    amAccQ <= 42'sh00000000000;
                end else if (v2Q) begin
                    amAccQ <= amAccQ + {{24{magDiff[17]}}, magDiff};
                end
            end

            // Readback shows the value in force, so software can watch the loops
            wire [15:0] rdCtrl  = ctrlQ;
            wire [15:0] rdDcI   = dcIUse;
            wire [15:0] rdDcQ   = dcQUse;
            wire [15:0] rdPhase = phAuto ? {{2{phEstQ[13]}}, phEstQ} : phaseQ;
            wire [15:0] rdAmp   = amAuto ? {{2{amEstQ[13]}}, amEstQ} : ampQ;
        end
    endgenerate

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        case (busIdx)
            4'h0:    rdMux = {16'h0000, pairGen[0].rdCtrl};
            4'h1:    rdMux = {16'h0000, pairGen[1].rdCtrl};
            4'h2:    rdMux = {16'h0000, pairGen[0].rdDcI};
            4'h3:    rdMux = {16'h0000, pairGen[0].rdDcQ};
            4'h4:    rdMux = {16'h0000, pairGen[1].rdDcI};
            4'h5:    rdMux = {16'h0000, pairGen[1].rdDcQ};
            4'h6:    rdMux = {16'h0000, pairGen[0].rdPhase};
            4'h7:    rdMux = {16'h0000, pairGen[0].rdAmp};
            4'h8:    rdMux = {16'h0000, pairGen[1].rdPhase};
            4'h9:    rdMux = {16'h0000, pairGen[1].rdAmp};
            4'ha:    rdMux = {6'h00, cplxCdQ, cplxAbQ, 23'h000000, lvdsQ};
            default: rdMux = 32'h00000000;
        endcase
    end

    // Corrected outputs, all from flip-flops
    assign corrA = pairGen[0].iOutQ;
    assign corrB = pairGen[0].qOutQ;
    assign corrC = pairGen[1].iOutQ;
    assign corrD = pairGen[1].qOutQ;

endmodule

//--- verification/iqc_adc_model.sv
// Behavioural ADC source feeding the four sample ports
`timescale 1ns/100ps
module iqc_adc_model (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Sample request from the bench
    input  wire        sendReq,
    input  wire [63:0] sendWord,
    // Sample ports, A in the top lane
    output reg         adcValid,
    output reg  [63:0] adcBus
);
    // Lines invert between samples, so stale data never passes for a fresh one
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adcValid <= 1'b0;
            adcBus <= 64'h0;
        end else begin
            adcValid <= sendReq;
            adcBus <= sendReq ? sendWord : ~adcBus;
        end
    end
endmodule

//--- verification/iqc_correction_assertions.sv
// Port checker for the I/Q correction block
`timescale 1ns/100ps
module iqc_correction_assertions (
    // Clock, reset and register bus
    input wire        clk,
    input wire        rstn,
    input wire [7:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [3:0]  byteenable,
    input wire [31:0] readdata,
    input wire        waitrequest,
    // Sample streams
    input wire        adcValid,
    input wire [15:0] adcA,
    input wire [15:0] adcB,
    input wire [15:0] adcC,
    input wire [15:0] adcD,
    input wire        corrValid,
    input wire [15:0] corrA,
    input wire [15:0] corrB,
    input wire [15:0] corrC,
    input wire [15:0] corrD
);
    reg  [2:0] mode_q;
    wire       realAb = !mode_q[1] || mode_q[0];
    wire       realCd = !mode_q[2] || mode_q[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Shadow of the pair mode bits; only the bus tells us the mode
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= 3'h0;
        end else if (write && !waitrequest && address[7:2] == 6'h0a) begin
            if (byteenable[3]) mode_q[2:1] <= writedata[25:24];
            if (byteenable[0]) mode_q[0] <= writedata[0];
        end
    end
    // Bus handshake and unmapped space
    wait_first_a: assert property ((read || write) && !$past(read || write) |-> waitrequest)
        else $error("first request cycle not stalled");
    one_wait_a: assert property (waitrequest |=> !waitrequest)
        else $error("more than one wait state");
    idle_free_a: assert property (!(read || write) |-> !waitrequest)
        else $error("wait state without request");
    unmapped_zero_a: assert property (read && !waitrequest && address[7:2] > 6'h0a |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    // Stream timing and hold
    sample_lat_a: assert property (adcValid |-> ##2 corrValid)
        else $error("result not two cycles after sample");
    no_extra_a: assert property (!adcValid |-> ##2 !corrValid)
        else $error("result without sample");
    corr_hold_a: assert property (!corrValid |-> $stable({corrA, corrB, corrC, corrD}))
        else $error("outputs moved between samples");
    // Real pairs, or differential input, pass samples untouched
    real_ab_a: assert property (adcValid && realAb |-> ##2
        corrA == $past(adcA, 2) && corrB == $past(adcB, 2)) else $error("real AB pair altered");
    real_cd_a: assert property (adcValid && realCd |-> ##2
        corrC == $past(adcC, 2) && corrD == $past(adcD, 2)) else $error("real CD pair altered");
    cover property (adcValid && !realAb && !realCd);
    cover property (read && !waitrequest && address == 8'h08);
    cover property (write && !waitrequest && address == 8'h28);
endmodule
bind iqc_correction iqc_correction_assertions chk (.clk(clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .adcValid(adcValid), .adcA(adcA), .adcB(adcB), .adcC(adcC),
    .adcD(adcD), .corrValid(corrValid), .corrA(corrA), .corrB(corrB), .corrC(corrC), .corrD(corrD));

//--- verification/tb_iqc_correction.sv
// Self-checking bench for the I/Q correction block
`timescale 1ns/100ps
module tb_iqc_correction;
    reg         clk;
    reg         rstn;
    reg  [7:0]  address;
    reg         read;
    reg         write;
    reg  [31:0] writedata;
    reg  [3:0]  byteenable;
    wire [31:0] readdata;
    wire        waitrequest;
    reg         sendReq;
    reg  [63:0] sendWord;
    wire        adcValid;
    wire [63:0] adcBus;
    wire        corrValid;
    wire [63:0] corrBus;
    reg  [31:0] rd;
    integer     error_cnt;
    integer     check_count;
    integer     i;
    integer     cv [0:7] = '{100, -50, -300, 20, 2048, -1024, -4096, 4095};
    integer     sa [0:2] = '{1000, 32767, -32768};
    integer     sb [0:2] = '{2000, 32767, -20000};
    integer     sc [0:2] = '{-3000, -32768, 32000};
    integer     sd [0:2] = '{400, -32768, 5};

    iqc_adc_model adc (.clk(clk), .rstn(rstn), .sendReq(sendReq), .sendWord(sendWord),
        .adcValid(adcValid), .adcBus(adcBus));
    iqc_correction dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .adcValid(adcValid), .adcA(adcBus[63:48]), .adcB(adcBus[47:32]), .adcC(adcBus[31:16]),
        .adcD(adcBus[15:0]), .corrValid(corrValid), .corrA(corrBus[63:48]), .corrB(corrBus[47:32]),
        .corrC(corrBus[31:16]), .corrD(corrBus[15:0]));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Reference arithmetic: dc subtract with clamp, then scaled coefficient-times-Q terms
    function [15:0] sat(input integer v);
        sat = v > 32767 ? 16'h7fff : (v < -32768 ? 16'h8000 : v[15:0]);
    endfunction
    function [31:0] pair(input integer i, q, di, dq, p, m);
        integer a, b;
        begin
            a = $signed(sat(i - di));
            b = $signed(sat(q - dq));
            pair = {sat(a + ((p * b) >>> 13)), sat(b + ((m * b) >>> 13))};
        end
    endfunction
    function [63:0] w4(input integer a, b, c, d);
        w4 = {a[15:0], b[15:0], c[15:0], d[15:0]};
    endfunction
    function [31:0] pat(input integer k);
        pat = (k * 32'h1357 + 32'h2468) & 32'hfff8;
    endfunction

    task check(input [63:0] seen, input [63:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // One bus transfer, held until waitrequest is seen low at an edge
    task bus(input wr, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            address <= a;
            writedata <= d;
            write <= wr;
            read <= !wr;
            n = 0;
            // Look at settled values mid-cycle; act on the next rising edge
            @(negedge clk);
            while (waitrequest !== 1'b0 && n < 50) begin
                n = n + 1;
                @(negedge clk);
            end
            if (n == 50) error_cnt = error_cnt + 1;
            rd = readdata;
            @(posedge clk);
            write <= 1'b0;
            read <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            check({32'h0, rd}, {32'h0, e});
        end
    endtask

    // One sample through the model, result compared when it shows
    task smp(input [63:0] w, input [63:0] e);
        integer n;
        begin
            @(posedge clk);
            sendReq <= 1'b1;
            sendWord <= w;
            @(posedge clk);
            sendReq <= 1'b0;
            n = 0;
            while (corrValid !== 1'b1 && n < 20) begin
                n = n + 1;
                @(negedge clk);
            end
            if (n == 20) error_cnt = error_cnt + 1;
            check(corrBus, e);
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        #120000;
        error_cnt = error_cnt + 1;
        stop_test;
    end

    // Main sequence
    initial begin
        rstn = 1'b0;
        {read, write, sendReq} = 3'h0;
        {address, writedata, sendWord} = 104'h0;
        byteenable = 4'hf;
        error_cnt = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 11; i = i + 1)
            rdc(8'(i * 4), 32'h0);
        for (i = 0; i < 10; i = i + 1)
            wr(8'(i * 4), 32'hffff0000 | pat(i));
        for (i = 0; i < 10; i = i + 1)
            rdc(8'(i * 4), pat(i));
        wr(8'h2c, 32'hffffffff);
        rdc(8'h2c, 32'h0);
        rdc(8'h40, 32'h0);
        $display("test registers done");
        // Real pairs ignore enables and written values
        wr(8'h00, 32'h7);
        wr(8'h04, 32'h7);
        smp(w4(1000, -2000, 3000, -4000), w4(1000, -2000, 3000, -4000));
        $display("test real mode done");
        // Complex pairs, written corrections, reserved bit set
        wr(8'h00, 32'h8);
        wr(8'h04, 32'h8);
        for (i = 0; i < 8; i = i + 1)
            wr(8'(8 + i * 4), cv[i]);
        wr(8'h28, 32'h03000000);
        for (i = 0; i < 3; i = i + 1)
            smp(w4(sa[i], sb[i], sc[i], sd[i]), {pair(sa[i], sb[i], cv[0], cv[1], cv[4], cv[5]),
                pair(sc[i], sd[i], cv[2], cv[3], cv[6], cv[7])});
        $display("test manual correction done");
        wr(8'h28, 32'h03000001);
        smp(w4(5, 6, 7, 8), w4(5, 6, 7, 8));
        $display("test differential input done");
        // Second reset, then automatic dc removal at two rates, AB loops all automatic
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        wr(8'h00, 32'h7);
        wr(8'h04, 32'h11);
        wr(8'h28, 32'h03000000);
        @(posedge clk);
        sendReq <= 1'b1;
        sendWord <= w4(700, -512, 1234, -77);
        repeat (6000) @(posedge clk);
        sendReq <= 1'b0;
        rdc(8'h08, 32'd700);
        rdc(8'h0c, 32'hfe00);
        rdc(8'h10, 32'h0);
        rdc(8'h18, 32'h1);
        rdc(8'h1c, 32'h1);
        smp(w4(700, -512, 1234, -77), w4(0, 0, 1234, -77));
        $display("test automatic dc done");
        stop_test;
    end
endmodule
